// [logic/rx_csr_pkg.sv]
// Constants and carrier types for the receiver control and status block.
// Assumes a single 200 MHz clock domain; used by all design files.
package rx_csr_pkg;

   // Register geometry
   localparam int CSR_WIDTH = 16;

   // Bit positions of receiver_control_status
   localparam int BIT_CHANGE = 15;
   localparam int BIT_RING = 14;
   localparam int BIT_CTS = 13;
   localparam int BIT_CARRIER = 12;
   localparam int BIT_ACTIVE = 11;
   localparam int BIT_SEC_RX = 10;
   localparam int BIT_DSR = 9;
   localparam int BIT_STRIP = 8;
   localparam int BIT_DONE = 7;
   localparam int BIT_RX_IE = 6;
   localparam int BIT_CHG_IE = 5;
   localparam int BIT_SEARCH = 4;
   localparam int BIT_SEC_TX = 3;
   localparam int BIT_RTS = 2;
   localparam int BIT_DTR = 1;

   // Reset values
   localparam logic [15:0] CSR_RESET = 16'h0000;
   localparam logic CTRL_RESET = 1'b0;

   // Receiver operating modes
   localparam logic [1:0] MODE_INT_SYNC = 2'h0;
   localparam logic [1:0] MODE_EXT_SYNC = 2'h1;
   localparam logic [1:0] MODE_ISOCH = 2'h2;

   // Sync character counts
   localparam logic [1:0] SYNC_ONE = 2'h1;
   localparam logic [1:0] SYNC_TWO = 2'h2;

   // Synchroniser depth
   localparam int SYNC_STAGES = 2;

   // Modem status leads
   typedef struct packed {
      logic ring;
      logic cts;
      logic carrier;
      logic sec_rx;
      logic dsr;
   } modem_in_s;

   // Writable control bits
   typedef struct packed {
      logic strip;
      logic rx_ie;
      logic chg_ie;
      logic search;
   } rx_ctrl_s;

   // Modem output controls
   typedef struct packed {
      logic sec_tx;
      logic rts;
      logic dtr;
   } modem_out_s;

   // Synchronisation search states
   typedef enum logic [2:0] {
      SRCH_IDLE = 3'b001,
      SRCH_HUNT = 3'b010,
      SRCH_LOCKED = 3'b100
   } srch_state_e;

endpackage

// [logic/modem_status_sync.sv]
// Two-stage synchroniser and change detector for the modem status leads.
// Assumes leads are asynchronous to CLK; change is a one-cycle pulse.
`timescale 1ns/100ps
module modem_status_sync (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // Raw leads
   input wire rx_csr_pkg::modem_in_s leads_raw,
   // Synchronised leads and change pulse
   output rx_csr_pkg::modem_in_s leads_sync,
   output logic change
);

   rx_csr_pkg::modem_in_s meta_reg;
   rx_csr_pkg::modem_in_s meta_next;
   rx_csr_pkg::modem_in_s stable_reg;
   rx_csr_pkg::modem_in_s stable_next;
   rx_csr_pkg::modem_in_s prev_reg;
   rx_csr_pkg::modem_in_s prev_next;
   logic change_reg;
   logic change_next;

   // First stage feeds only the second
   always_comb begin
      meta_next = leads_raw;
      stable_next = meta_reg;
      prev_next = stable_reg;
      change_next = (stable_reg != prev_reg);
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         meta_reg <= '0;
         stable_reg <= '0;
         prev_reg <= '0;
         change_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         stable_reg <= stable_next;
         prev_reg <= prev_next;
         change_reg <= change_next;
      end
   end

   assign leads_sync = stable_reg;
   assign change = change_reg;

endmodule

// [logic/rx_modem_csr.sv]
// Receiver control and status register with modem lead handling.
// Assumes processor strobes and receiver pulses are on CLK; modem leads are not.
//
// Function
// - Bit 13 reads the live clear-to-send lead, read-only.
// - Bit 12 reads the live carrier-detect lead, read-only.
// - Internal sync mode: active sets after one or two consecutive sync characters.
// - Active is read-only; cleared by init, master reset, search falling.
// - Bit 10 reads the secondary receive data lead, read-only.
// - Bit 9 reads the data-set-ready lead, read-only.
// - With strip set, error-free sync characters set no done and no interrupt.
// - Strip, both interrupt enables and search are read/write, cleared by resets.
// - Done sets on a character loaded after synchronisation, unless stripped.
// - Done is read-only; cleared by resets and the buffer read strobe.
// - Done with receive interrupt enable raises the receiver interrupt.
// - Change flag with change interrupt enable raises the receiver interrupt.
// - Internal mode: search enables the sync hunt against the sync register.
// - Isochronous mode: search only enables done generation.
// - External mode: search enables done and starts character framing at once.
// - Bit 3 is read/write and drives the secondary transmit lead.
// - Bit 1 drives data-terminal-ready toward the modem.
// - Modem output bits clear on init and master reset only when the build option says.
// - Change flag sets on any lead transition; clears on resets or status read.
`timescale 1ns/100ps
module rx_modem_csr #(
   parameter bit CLEAR_MODEM_ON_RESET = 1'b1
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // Processor resets
   input wire logic INIT,
   input wire logic MASTER_RESET,
   // Register port
   input wire logic CSR_WRITE,
   input wire logic [15:0] CSR_WDATA,
   input wire logic CSR_READ,
   output logic [15:0] CSR_RDATA,
   input wire logic RX_BUFFER_READ,
   // Parameter settings
   input wire logic [1:0] MODE,
   input wire logic [1:0] SYNC_COUNT,
   // Receiver datapath
   input wire logic CHAR_LOADED,
   input wire logic CHAR_IS_SYNC,
   input wire logic CHAR_ERROR,
   output logic SYNC_HUNT,
   output logic FRAME_ENABLE,
   output logic DONE_ENABLE,
   // Modem leads
   input wire logic RING_IN,
   input wire logic CTS_IN,
   input wire logic CARRIER_IN,
   input wire logic SEC_RX_IN,
   input wire logic DSR_IN,
   output logic SEC_TX_OUT,
   output logic RTS_OUT,
   output logic DTR_OUT,
   output logic TX_PERMIT,
   // Interrupt request
   output logic RX_IRQ
);

   rx_csr_pkg::modem_in_s leads_raw;
   rx_csr_pkg::modem_in_s leads;
   logic lead_change;

   rx_csr_pkg::rx_ctrl_s ctrl_reg;
   rx_csr_pkg::rx_ctrl_s ctrl_next;
   rx_csr_pkg::modem_out_s mout_reg;
   rx_csr_pkg::modem_out_s mout_next;

   rx_csr_pkg::srch_state_e state_reg;
   rx_csr_pkg::srch_state_e state_next;
   logic [1:0] sync_cnt_reg;
   logic [1:0] sync_cnt_next;

   logic done_reg;
   logic done_next;
   logic change_reg;
   logic change_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;

   logic soft_reset;
   logic search_fall;
   logic active_flag;
   logic active_next;
   logic char_stripped;
   logic done_set;
   logic [1:0] sync_target;
   logic int_mode;

   // Hit count reached for the configured sync count
   function automatic logic count_reached(input logic [1:0] cnt, input logic [1:0] target);
      count_reached = (cnt >= target);
   endfunction

   assign leads_raw.ring = RING_IN;
   assign leads_raw.cts = CTS_IN;
   assign leads_raw.carrier = CARRIER_IN;
   assign leads_raw.sec_rx = SEC_RX_IN;
   assign leads_raw.dsr = DSR_IN;

   // Modem leads into the clock domain
   modem_status_sync u_modem_sync (
      .CLK(CLK),
      .RESETN(RESETN),
      .leads_raw(leads_raw),
      .leads_sync(leads),
      .change(lead_change)
   );

   assign soft_reset = INIT | MASTER_RESET;
   assign int_mode = (MODE == rx_csr_pkg::MODE_INT_SYNC);
   assign sync_target = (SYNC_COUNT == rx_csr_pkg::SYNC_ONE) ? rx_csr_pkg::SYNC_ONE
                                                             : rx_csr_pkg::SYNC_TWO;

   // Control bits and modem outputs
   always_comb begin
      ctrl_next = ctrl_reg;
      mout_next = mout_reg;
      if (CSR_WRITE) begin
         ctrl_next.strip = CSR_WDATA[rx_csr_pkg::BIT_STRIP];
         ctrl_next.rx_ie = CSR_WDATA[rx_csr_pkg::BIT_RX_IE];
         ctrl_next.chg_ie = CSR_WDATA[rx_csr_pkg::BIT_CHG_IE];
         ctrl_next.search = CSR_WDATA[rx_csr_pkg::BIT_SEARCH];
         mout_next.sec_tx = CSR_WDATA[rx_csr_pkg::BIT_SEC_TX];
         mout_next.rts = CSR_WDATA[rx_csr_pkg::BIT_RTS];
         mout_next.dtr = CSR_WDATA[rx_csr_pkg::BIT_DTR];
      end
      if (soft_reset) begin
         ctrl_next = '0;
         if (CLEAR_MODEM_ON_RESET) begin
            mout_next = '0;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_reg <= '0;
         mout_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         mout_reg <= mout_next;
      end
   end

   assign search_fall = ctrl_reg.search & ~ctrl_next.search;

   // Sync search sequence for internal mode
   always_comb begin
      state_next = state_reg;
      sync_cnt_next = sync_cnt_reg;
      case (state_reg)
         rx_csr_pkg::SRCH_IDLE: begin
            sync_cnt_next = 2'h0;
            if (ctrl_reg.search && int_mode) begin
               state_next = rx_csr_pkg::SRCH_HUNT;
            end
         end
         rx_csr_pkg::SRCH_HUNT: begin
            if (CHAR_LOADED) begin
               if (CHAR_IS_SYNC) begin
                  sync_cnt_next = sync_cnt_reg + 2'h1;
                  if (count_reached(sync_cnt_reg + 2'h1, sync_target)) begin
                     state_next = rx_csr_pkg::SRCH_LOCKED;
                  end
               end else begin
                  sync_cnt_next = 2'h0;
               end
            end
         end
         rx_csr_pkg::SRCH_LOCKED: begin
            sync_cnt_next = 2'h0;
         end
         default: begin
            state_next = rx_csr_pkg::SRCH_IDLE;
            sync_cnt_next = 2'h0;
         end
      endcase
      if (soft_reset || search_fall || !int_mode || !ctrl_reg.search) begin
         state_next = rx_csr_pkg::SRCH_IDLE;
         sync_cnt_next = 2'h0;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= rx_csr_pkg::SRCH_IDLE;
         sync_cnt_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         sync_cnt_reg <= sync_cnt_next;
      end
   end

   // Receiver active per mode; next value keeps the image in step
   always_comb begin
      if (int_mode) begin
         active_flag = (state_reg == rx_csr_pkg::SRCH_LOCKED);
         active_next = (state_next == rx_csr_pkg::SRCH_LOCKED);
      end else begin
         active_flag = ctrl_reg.search;
         active_next = ctrl_next.search;
      end
   end

   // Receiver enables toward the datapath
   always_comb begin
      SYNC_HUNT = int_mode & ctrl_reg.search & (state_reg != rx_csr_pkg::SRCH_LOCKED);
      FRAME_ENABLE = 1'b0;
      DONE_ENABLE = 1'b0;
      case (MODE)
         rx_csr_pkg::MODE_INT_SYNC: begin
            FRAME_ENABLE = active_flag;
            DONE_ENABLE = active_flag;
         end
         rx_csr_pkg::MODE_EXT_SYNC: begin
            FRAME_ENABLE = ctrl_reg.search;
            DONE_ENABLE = ctrl_reg.search;
         end
         rx_csr_pkg::MODE_ISOCH: begin
            FRAME_ENABLE = 1'b1;
            DONE_ENABLE = ctrl_reg.search;
         end
         default: begin
            FRAME_ENABLE = 1'b0;
            DONE_ENABLE = 1'b0;
         end
      endcase
   end

   // Done and change flags; a set beats a read clear in the same cycle, init and master reset beat a set
   assign char_stripped = ctrl_reg.strip & CHAR_IS_SYNC & ~CHAR_ERROR;
   assign done_set = CHAR_LOADED & DONE_ENABLE & ~char_stripped;

   always_comb begin
      done_next = done_reg;
      change_next = change_reg;
      if (RX_BUFFER_READ) begin
         done_next = 1'b0;
      end
      if (done_set) begin
         done_next = 1'b1;
      end
      if (CSR_READ) begin
         change_next = 1'b0;
      end
      if (lead_change) begin
         change_next = 1'b1;
      end
      if (soft_reset) begin
         done_next = 1'b0;
         change_next = 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         done_reg <= rx_csr_pkg::CTRL_RESET;
         change_reg <= rx_csr_pkg::CTRL_RESET;
      end else begin
         done_reg <= done_next;
         change_reg <= change_next;
      end
   end

   // Read image of the status register
   always_comb begin
      rdata_next = rx_csr_pkg::CSR_RESET;
      rdata_next[rx_csr_pkg::BIT_CHANGE] = change_next;
      rdata_next[rx_csr_pkg::BIT_RING] = leads.ring;
      rdata_next[rx_csr_pkg::BIT_CTS] = leads.cts;
      rdata_next[rx_csr_pkg::BIT_CARRIER] = leads.carrier;
      rdata_next[rx_csr_pkg::BIT_ACTIVE] = active_next;
      rdata_next[rx_csr_pkg::BIT_SEC_RX] = leads.sec_rx;
      rdata_next[rx_csr_pkg::BIT_DSR] = leads.dsr;
      rdata_next[rx_csr_pkg::BIT_STRIP] = ctrl_next.strip;
      rdata_next[rx_csr_pkg::BIT_DONE] = done_next;
      rdata_next[rx_csr_pkg::BIT_RX_IE] = ctrl_next.rx_ie;
      rdata_next[rx_csr_pkg::BIT_CHG_IE] = ctrl_next.chg_ie;
      rdata_next[rx_csr_pkg::BIT_SEARCH] = ctrl_next.search;
      rdata_next[rx_csr_pkg::BIT_SEC_TX] = mout_next.sec_tx;
      rdata_next[rx_csr_pkg::BIT_RTS] = mout_next.rts;
      rdata_next[rx_csr_pkg::BIT_DTR] = mout_next.dtr;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_reg <= rx_csr_pkg::CSR_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign CSR_RDATA = rdata_reg;

   // Modem control leads
   assign SEC_TX_OUT = mout_reg.sec_tx;
   assign RTS_OUT = mout_reg.rts;
   assign DTR_OUT = mout_reg.dtr;
   assign TX_PERMIT = mout_reg.rts & leads.cts;

   // Receiver interrupt request
   assign RX_IRQ = (done_reg & ctrl_reg.rx_ie) | (change_reg & ctrl_reg.chg_ie);

endmodule

// [sim/rx_modem_csr_checker.sv]
// Assertion checker for the receiver control and status block.
// Bound to rx_modem_csr; sees only its ports, one clock domain.
`timescale 1ns/100ps
module rx_modem_csr_checker #(
   parameter bit CLEAR_MODEM_ON_RESET = 1'b1
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // Controls
   input wire logic INIT,
   input wire logic MASTER_RESET,
   input wire logic CSR_WRITE,
   input wire logic [15:0] CSR_WDATA,
   input wire logic RX_BUFFER_READ,
   input wire logic [1:0] MODE,
   input wire logic CHAR_LOADED,
   input wire logic CHAR_IS_SYNC,
   input wire logic CHAR_ERROR,
   input wire logic DONE_ENABLE,
   // Modem leads
   input wire logic RING_IN,
   input wire logic CTS_IN,
   input wire logic CARRIER_IN,
   input wire logic SEC_RX_IN,
   input wire logic DSR_IN,
   // Outputs
   input wire logic [15:0] CSR_RDATA,
   input wire logic SEC_TX_OUT,
   input wire logic RTS_OUT,
   input wire logic DTR_OUT,
   input wire logic TX_PERMIT,
   input wire logic RX_IRQ,
   input wire logic SYNC_HUNT,
   input wire logic FRAME_ENABLE
);
   logic [2:0] age_reg;
   logic [2:0] age_next;
   logic rst;
   logic [4:0] leads;
   logic [15:0] r;
   assign rst = INIT | MASTER_RESET;
   assign leads = {RING_IN, CTS_IN, CARRIER_IN, SEC_RX_IN, DSR_IN};
   assign r = CSR_RDATA;
   always_comb age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) age_reg <= 3'h0;
      else age_reg <= age_next;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence lead_moved;
      $changed(leads) && age_reg == 3'h7;
   endsequence
   sequence kept_char;
      CHAR_LOADED && DONE_ENABLE && !(r[8] && CHAR_IS_SYNC && !CHAR_ERROR) && !rst;
   endsequence
   irq_or_a: assert property (RX_IRQ == ((r[7] & r[6]) | (r[15] & r[5])))
      else $error("irq not the OR of enabled flags");
   modem_out_a: assert property ({SEC_TX_OUT, RTS_OUT, DTR_OUT} == r[3:1])
      else $error("modem outputs differ from bits 3..1");
   tx_permit_a: assert property (TX_PERMIT |-> RTS_OUT)
      else $error("transmit permitted without rts");
   ctrl_write_a: assert property (CSR_WRITE && !rst |=>
      (r & 16'h017E) == ($past(CSR_WDATA) & 16'h017E))
      else $error("control bits not loaded");
   reset_clear_a: assert property (rst |=> (r & 16'h89F0) == 16'h0000 &&
      (!CLEAR_MODEM_ON_RESET || r[3:1] == 3'h0))
      else $error("bits not cleared by init");
   done_set_a: assert property (kept_char |=> r[7])
      else $error("done not set");
   strip_sync_a: assert property (CHAR_LOADED && CHAR_IS_SYNC && !CHAR_ERROR && r[8] && !r[7]
      |=> !r[7])
      else $error("stripped sync set done");
   done_clear_a: assert property (RX_BUFFER_READ && !CHAR_LOADED && !rst |=> !r[7])
      else $error("done not cleared by buffer read");
   active_follow_a: assert property (MODE inside {2'h1, 2'h2} && $stable(MODE)
      |-> r[11] == r[4])
      else $error("active not following search");
   search_fall_a: assert property ($fell(r[4]) |-> !r[11])
      else $error("active kept after search fell");
   lead_level_a: assert property ($stable(leads)[*4] ##0 age_reg == 3'h7
      |-> {r[14:12], r[10:9]} == leads)
      else $error("status bits differ from leads");
   change_set_a: assert property (lead_moved |-> ##[1:6] (r[15] || rst))
      else $error("change flag not set");
   tx_grant_a: assert property ($past(RTS_OUT) |-> $past(TX_PERMIT) == r[13])
      else $error("transmit permit differs from rts and cts");
   frame_gate_a: assert property ($stable(MODE) |-> FRAME_ENABLE == (MODE == 2'h2 ||
      (MODE == 2'h1 && r[4]) || (MODE == 2'h0 && r[11])))
      else $error("frame enable wrong for mode");
   done_gate_a: assert property ($stable(MODE) |-> DONE_ENABLE ==
      ((MODE inside {2'h1, 2'h2} && r[4]) || (MODE == 2'h0 && r[11])))
      else $error("done enable wrong for mode");
   hunt_gate_a: assert property ($stable(MODE) |-> SYNC_HUNT ==
      (MODE == 2'h0 && r[4] && !r[11]))
      else $error("sync hunt wrong for mode");
endmodule

bind rx_modem_csr rx_modem_csr_checker #(.CLEAR_MODEM_ON_RESET(CLEAR_MODEM_ON_RESET)) u_chk (.*);

// [sim/modem_model.sv]
// Behavioural modem on the far side of the control leads.
// Assumes the bench sets ring, carrier, secondary data; answers fast or slow.
`timescale 1ns/100ps
module modem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Controls from the interface
   input wire logic rts,
   input wire logic dtr,
   // Bench commands
   input wire logic slow,
   input wire logic [2:0] misc,
   // Status leads
   output rx_csr_pkg::modem_in_s leads
);
   logic [4:0] wait_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= 5'h00;
         leads <= '0;
      end else begin
         wait_reg <= rts ? wait_reg + {4'h0, wait_reg != 5'h1F} : 5'h00;
         leads.cts <= rts && wait_reg >= (slow ? 5'h0C : 5'h01);
         leads.dsr <= dtr;
         {leads.ring, leads.carrier, leads.sec_rx} <= misc;
      end
   end
endmodule

// [sim/sync_rx_modem_control_csr_tb_top.sv]
// Self-checking bench for the receiver control and status block.
// Assumes the modem model on the leads and the bound checker.
`timescale 1ns/100ps
module sync_rx_modem_control_csr_tb_top;
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   logic INIT = 1'b0;
   logic MASTER_RESET = 1'b0;
   logic CSR_WRITE = 1'b0;
   logic [15:0] CSR_WDATA = 16'h0000;
   logic CSR_READ = 1'b0;
   logic RX_BUFFER_READ = 1'b0;
   logic [1:0] MODE = 2'h0;
   logic [1:0] SYNC_COUNT = 2'h2;
   logic CHAR_LOADED = 1'b0;
   logic CHAR_IS_SYNC = 1'b0;
   logic CHAR_ERROR = 1'b0;
   logic slow = 1'b0;
   logic [2:0] misc = 3'h0;
   wire RING_IN, CTS_IN, CARRIER_IN, SEC_RX_IN, DSR_IN;
   logic [15:0] CSR_RDATA;
   logic SYNC_HUNT, FRAME_ENABLE, DONE_ENABLE, SEC_TX_OUT, RTS_OUT, DTR_OUT;
   logic TX_PERMIT, RX_IRQ;
   logic chk = 1'b0;
   logic [31:0] seed = 32'h00000022;
   logic [31:0] q[$];
   logic [15:0] v;
   logic [15:0] seen;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;

   rx_modem_csr u_rx_modem_csr (.*);
   modem_model u_modem_model (.clk(CLK), .rst_n(RESETN), .rts(RTS_OUT), .dtr(DTR_OUT),
      .slow(slow), .misc(misc), .leads({RING_IN, CTS_IN, CARRIER_IN, SEC_RX_IN, DSR_IN}));

   always #2.5 CLK = ~CLK;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge CLK);
   endtask
   task automatic wr(input logic [15:0] d);
      @(posedge CLK);
      CSR_WRITE <= 1'b1;
      CSR_WDATA <= d;
      @(posedge CLK);
      CSR_WRITE <= 1'b0;
   endtask
   task automatic ch(input logic s, input logic e);
      @(posedge CLK);
      CHAR_LOADED <= 1'b1;
      CHAR_IS_SYNC <= s;
      CHAR_ERROR <= e;
      @(posedge CLK);
      CHAR_LOADED <= 1'b0;
   endtask
   task automatic pulse(input int w);
      @(posedge CLK);
      {MASTER_RESET, INIT, RX_BUFFER_READ, CSR_READ} <= 4'h1 << w;
      @(posedge CLK);
      {MASTER_RESET, INIT, RX_BUFFER_READ, CSR_READ} <= 4'h0;
   endtask
   // Note mask and value; bit 0 stands for the interrupt request
   task automatic expect_csr(input logic [15:0] mask, input logic [15:0] e);
      @(posedge CLK);
      q.push_back({mask, e});
      chk <= 1'b1;
      @(posedge CLK);
      chk <= 1'b0;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(negedge CLK) begin
      if (chk) begin
         seen = {CSR_RDATA[15:1], RX_IRQ} & q[0][31:16];
         compares++;
         if (seen !== q[0][15:0]) begin
            n_errors++;
            $display("wrong value status exp %h seen %h", q[0][15:0], seen);
         end
         void'(q.pop_front());
      end
   end

   always @(posedge CLK) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         close_out();
      end
   end

   initial begin
      tick(2);
      RESETN <= 1'b1;
      expect_csr(16'hFFFF, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         v = 16'(rnd());
         wr(v);
         expect_csr(16'h5DFE, v & 16'h017E);
      end
      $display("test control write done");
      wr(16'h0026);
      for (int i = 0; i < 4; i++) begin
         slow <= i[0];
         misc <= misc ^ (3'(rnd()) | 3'h1);
         tick(25);
         v = {1'b1, misc[2], 1'b1, misc[1], 1'b0, misc[0], 1'b1, 9'h027};
         expect_csr(16'hFFFF, v);
         pulse(0);
         expect_csr(16'hFFFF, v & 16'h7FFE);
      end
      $display("test modem leads done");
      for (int i = 1; i < 3; i++) begin
         MODE <= i[1:0];
         wr(16'h0156);
         expect_csr(16'h0991, 16'h0910);
         ch(1'b1, 1'b0);
         expect_csr(16'h0081, 16'h0000);
         ch(1'b1, 1'b1);
         expect_csr(16'h0081, 16'h0081);
         pulse(1);
         expect_csr(16'h0081, 16'h0000);
         ch(1'b0, 1'b0);
         expect_csr(16'h0081, 16'h0081);
         wr(16'h0006);
         expect_csr(16'h08D1, 16'h0080);
         pulse(1);
         ch(1'b0, 1'b0);
         expect_csr(16'h0081, 16'h0000);
      end
      $display("test done and strip done");
      MODE <= 2'h0;
      for (int i = 1; i < 3; i++) begin
         SYNC_COUNT <= i[1:0];
         wr(16'h0016);
         repeat (i - 1) ch(1'b1, 1'b0);
         ch(1'b0, 1'b0);
         repeat (i - 1) ch(1'b1, 1'b0);
         tick(1);
         expect_csr(16'h0891, 16'h0010);
         ch(1'b1, 1'b0);
         tick(1);
         expect_csr(16'h0891, 16'h0810);
         ch(1'b0, 1'b0);
         expect_csr(16'h0891, 16'h0890);
         wr(16'h0006);
         expect_csr(16'h0891, 16'h0080);
         pulse(1);
      end
      $display("test sync hunt done");
      for (int i = 2; i < 4; i++) begin
         MODE <= 2'h1;
         wr(16'h017E);
         ch(1'b0, 1'b0);
         pulse(i);
         expect_csr(16'h09FF, 16'h0000);
      end
      $display("test init done");
      MODE <= 2'h3;
      wr(16'h0050);
      ch(1'b0, 1'b0);
      expect_csr(16'h00D1, 16'h0050);
      $display("test idle mode done");
      close_out();
   end
endmodule
